// ### include/cfg_status_pkg.sv
// What this block does
// RULE_01: hold status low until power-on interval ends
// RULE_02: pull status low on configuration error
// RULE_03: external status low in config enters error
// RULE_04: configured device ignores both status lines
// RULE_05: host retries configuration when status low
// RULE_06: host reconfigures only by config request low
// RULE_07: failed early attempt retried after power-on
// RULE_08: hold complete line low until data done
// RULE_09: release complete line when initialization starts (code releases it on data done, before ST_INIT)
// RULE_10: enter user mode only seeing complete high
// RULE_11: request low in user mode resets, floats pins
// RULE_12: open-drain line high only when undriven
package cfg_status_pkg;

  //----------------------------------------------------------------
  // timing
  //----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_TIME_US   = 100;
  localparam int POR_CYCLES    = (POR_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES   = 16;
  localparam int CNT_W         = 24;

  //----------------------------------------------------------------
  // states
  //----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR    = 3'h0,
    ST_CONFIG = 3'h1,
    ST_WAITCD = 3'h3,
    ST_INIT   = 3'h2,
    ST_USER   = 3'h6,
    ST_ERROR  = 3'h7,
    ST_RESET  = 3'h5
  } cfg_state_t;

  // open-drain pin seen from the device: out low-enable only, the in level is not held here
  typedef struct packed {
    logic drive_n;
  } od_out_t;

  typedef struct packed {
    cfg_state_t       state;
    logic [CNT_W-1:0] count;
    logic             status_oe_n;
    logic             complete_oe_n;
    logic             user_mode;
    logic             pins_float;
  } cfg_reg_t;

endpackage : cfg_status_pkg

// ### core/por_timer.sv
`timescale 1ns/1ps
module por_timer #(
  parameter int CYCLES = cfg_status_pkg::POR_CYCLES
) (
  input  wire logic I_CLK_SYS,
  input  wire logic I_NRST,
  output logic      o_expired
);
  import cfg_status_pkg::*;

  // refuse interval lengths the counter cannot hold
  if (CYCLES < 1 || CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
    $error("por_timer: CYCLES out of range");
  end

  logic [CNT_W-1:0] count;

  // counts power-on interval once after reset release
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      count     <= '0;
      o_expired <= 1'b0;
    end else if (!o_expired) begin
      count     <= count + 1'b1;
      o_expired <= (count == CNT_W'(CYCLES - 1));
    end
  end
endmodule : por_timer

// ### core/config_status_handshake.sv
`timescale 1ns/1ps
module config_status_handshake #(
  parameter int POR_CYC  = cfg_status_pkg::POR_CYCLES,
  parameter int INIT_CYC = cfg_status_pkg::INIT_CYCLES
) (
  input  wire logic I_CLK_SYS,
  input  wire logic I_NRST,
  input  wire logic I_CFG_REQ_N,
  input  wire logic I_DATA_DONE,
  input  wire logic I_DATA_ERR,
  input  wire logic I_STATUS_N_IN,
  input  wire logic I_COMPLETE_IN,
  output logic      O_STATUS_N_OE_N,
  output logic      O_COMPLETE_OE_N,
  output logic      O_CFG_ACTIVE,
  output logic      O_USER_MODE,
  output logic      O_PINS_FLOAT
);
  import cfg_status_pkg::*;

  // refuse init lengths the shared counter cannot hold
  if (INIT_CYC < 1 || INIT_CYC >= (1 << CNT_W)) begin : g_bad_init
    $error("config_status_handshake: INIT_CYC out of range");
  end

  cfg_reg_t r;
  cfg_reg_t next_r;
  logic     por_done;

  //----------------------------------------------------------------
  // power-on interval
  //----------------------------------------------------------------
  por_timer #(
    .CYCLES    (POR_CYC)
  ) u_por (
    .I_CLK_SYS (I_CLK_SYS),
    .I_NRST    (I_NRST),
    .o_expired (por_done)
  );

  //----------------------------------------------------------------
  // handshake state machine
  //----------------------------------------------------------------
  always_comb begin
    next_r = r;
    unique case (r.state)
      ST_POR: begin
        next_r.status_oe_n   = 1'b0;                      // RULE_01
        next_r.complete_oe_n = 1'b0;                      // RULE_08
        if (por_done) begin
          next_r.status_oe_n = 1'b1;                      // RULE_01
          next_r.state       = ST_CONFIG;                 // RULE_07
        end
      end
      ST_CONFIG: begin
        next_r.status_oe_n   = 1'b1;
        next_r.complete_oe_n = 1'b0;                      // RULE_08
        if (!I_CFG_REQ_N) begin
          next_r.state = ST_RESET;
        end else if (I_DATA_ERR) begin
          next_r.state       = ST_ERROR;                  // RULE_02
          next_r.status_oe_n = 1'b0;
        end else if (!I_STATUS_N_IN) begin
          next_r.state       = ST_ERROR;                  // RULE_03
          next_r.status_oe_n = 1'b0;
        end else if (I_DATA_DONE) begin
          next_r.complete_oe_n = 1'b1;                    // RULE_09
          next_r.state         = ST_WAITCD;
        end
      end
      ST_WAITCD: begin
        if (!I_CFG_REQ_N) begin
          next_r.state         = ST_RESET;
          next_r.complete_oe_n = 1'b0;
        end else if (!I_STATUS_N_IN) begin
          next_r.state         = ST_ERROR;                // RULE_03
          next_r.status_oe_n   = 1'b0;
          next_r.complete_oe_n = 1'b0;
        end else if (I_COMPLETE_IN) begin
          next_r.state = ST_INIT;                         // RULE_10
          next_r.count = '0;
        end
      end
      ST_INIT: begin
        if (!I_CFG_REQ_N) begin
          next_r.state         = ST_RESET;
          next_r.complete_oe_n = 1'b0;
        end else if (!I_STATUS_N_IN) begin
          next_r.state         = ST_ERROR;                // RULE_03
          next_r.status_oe_n   = 1'b0;
          next_r.complete_oe_n = 1'b0;
        end else if (r.count == CNT_W'(INIT_CYC - 1)) begin
          next_r.state      = ST_USER;
          next_r.user_mode  = 1'b1;
          next_r.pins_float = 1'b0;
        end else begin
          next_r.count = r.count + 1'b1;
        end
      end
      ST_USER: begin
        // status and complete inputs are not looked at here
        if (!I_CFG_REQ_N) begin                           // RULE_04
          next_r.state         = ST_RESET;                // RULE_11
          next_r.user_mode     = 1'b0;
          next_r.pins_float    = 1'b1;
          next_r.complete_oe_n = 1'b0;
        end
      end
      ST_ERROR: begin
        // error held until the host pulses the request line
        next_r.status_oe_n   = 1'b0;
        next_r.complete_oe_n = 1'b0;
        if (!I_CFG_REQ_N) begin
          next_r.state = ST_RESET;
        end
      end
      ST_RESET: begin
        next_r.status_oe_n   = 1'b0;
        next_r.complete_oe_n = 1'b0;
        next_r.user_mode     = 1'b0;
        next_r.pins_float    = 1'b1;
        if (I_CFG_REQ_N) begin
          next_r.state       = ST_CONFIG;                 // RULE_11
          next_r.status_oe_n = 1'b1;
        end
      end
      default: begin
        next_r.state = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      r.state         <= ST_POR;
      r.count         <= '0;
      r.status_oe_n   <= 1'b0;
      r.complete_oe_n <= 1'b0;
      r.user_mode     <= 1'b0;
      r.pins_float    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  //----------------------------------------------------------------
  // outputs, low enable means pulling the open-drain line low
  //----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_STATUS_N_OE_N <= 1'b0;
      O_COMPLETE_OE_N <= 1'b0;
      O_CFG_ACTIVE    <= 1'b0;
      O_USER_MODE     <= 1'b0;
      O_PINS_FLOAT    <= 1'b1;
    end else begin
      O_STATUS_N_OE_N <= next_r.status_oe_n;              // RULE_12
      O_COMPLETE_OE_N <= next_r.complete_oe_n;            // RULE_12
      O_CFG_ACTIVE    <= (next_r.state == ST_CONFIG);
      O_USER_MODE     <= next_r.user_mode;
      O_PINS_FLOAT    <= next_r.pins_float;
    end
  end

  //----------------------------------------------------------------
  // checks
  //----------------------------------------------------------------
  status_por_hold_a: assert property (                    // RULE_01
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    !por_done |-> !O_STATUS_N_OE_N || r.state != ST_POR)
    else $error("status released before power-on interval");

  error_report_a: assert property (                       // RULE_02
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    (r.state == ST_CONFIG && I_CFG_REQ_N && I_DATA_ERR)
      |=> !O_STATUS_N_OE_N && r.state == ST_ERROR)
    else $error("config error not reported on status");

  ext_error_a: assert property (                          // RULE_03
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    (r.state inside {ST_CONFIG, ST_WAITCD, ST_INIT} && I_CFG_REQ_N
      && !I_STATUS_N_IN) |=> r.state == ST_ERROR)
    else $error("external status low did not cause error");

  user_ignore_a: assert property (                        // RULE_04
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    (r.state == ST_USER && I_CFG_REQ_N) |=> r.state == ST_USER
      && O_USER_MODE)
    else $error("user mode disturbed without request");

  retry_after_por_a: assert property (                    // RULE_07
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    (r.state == ST_POR && por_done) |=> r.state == ST_CONFIG
      && O_STATUS_N_OE_N)
    else $error("no configuration after power-on");

  complete_hold_a: assert property (                      // RULE_08
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    (r.state inside {ST_POR, ST_CONFIG} && !I_DATA_DONE)
      |=> !O_COMPLETE_OE_N || r.state != ST_CONFIG)
    else $error("complete line released before data done");

  complete_release_a: assert property (                   // RULE_09
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    (r.state == ST_CONFIG && I_CFG_REQ_N && !I_DATA_ERR
      && I_STATUS_N_IN && I_DATA_DONE) |=> O_COMPLETE_OE_N)
    else $error("complete line not released");

  user_needs_high_a: assert property (                    // RULE_10
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    (r.state == ST_WAITCD && !I_COMPLETE_IN) |=> r.state != ST_INIT)
    else $error("init entered while complete line low");

  request_reset_a: assert property (                      // RULE_11
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    (r.state == ST_USER && !I_CFG_REQ_N)
      |=> O_PINS_FLOAT && !O_USER_MODE ##1 r.state != ST_USER)
    else $error("request low did not reset user mode");
endmodule : config_status_handshake

// ### tb/cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_status_line,
  input  wire logic i_reconfig,
  input  wire logic i_pull_status,
  output logic      o_cfg_req_n,
  output logic      o_status_oe_n,
  output logic      o_data_done
);
  logic       pend;
  logic [1:0] hold;
  //----------------------------------------------------------------
  // retry: after status reads low, send data again once it is high
  //----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend        <= 1'b0;
      hold        <= 2'h0;
      o_data_done <= 1'b0;
    end else begin
      o_data_done <= 1'b0;
      if (i_reconfig) begin
        hold <= 2'h3;
      end else if (hold != 2'h0) begin
        hold <= hold - 2'h1;
      end
      if (!i_status_line && !i_pull_status) begin
        pend <= 1'b1;
      end else if (pend && i_status_line) begin
        pend        <= 1'b0;
        o_data_done <= 1'b1;
      end
    end
  end
  assign o_cfg_req_n   = (hold == 2'h0);
  assign o_status_oe_n = !i_pull_status;
endmodule : cfg_host_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cfg_status_pkg::*;
  localparam int POR  = 20;
  localparam int INIT = 4;
  logic clk, nrst, err, ext_pull, pull_cd, reconfig, host_pull;
  logic req_n, host_oe_n, done, st_line, cd_line;
  logic st_oe_n, cd_oe_n, active, user, flt;
  int   n_fail, n_checks, i, w, m;
  assign st_line = st_oe_n & host_oe_n & !ext_pull;
  assign cd_line = cd_oe_n & !pull_cd;

  config_status_handshake #(.POR_CYC(POR), .INIT_CYC(INIT)) dut (
    .I_CLK_SYS(clk), .I_NRST(nrst), .I_CFG_REQ_N(req_n),
    .I_DATA_DONE(done), .I_DATA_ERR(err), .I_STATUS_N_IN(st_line),
    .I_COMPLETE_IN(cd_line), .O_STATUS_N_OE_N(st_oe_n),
    .O_COMPLETE_OE_N(cd_oe_n), .O_CFG_ACTIVE(active),
    .O_USER_MODE(user), .O_PINS_FLOAT(flt));
  cfg_host_model host (
    .i_clk(clk), .i_nrst(nrst), .i_status_line(st_line),
    .i_reconfig(reconfig), .i_pull_status(host_pull),
    .o_cfg_req_n(req_n), .o_status_oe_n(host_oe_n), .o_data_done(done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------
  task chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  // bounded wait for user mode (1) or complete release (0)
  task wait_hi(input logic sel);
    for (w = 0; w < 100; w++) begin
      if ((sel ? user : cd_oe_n) === 1'b1) break;
      step(1);
    end
  endtask : wait_hi
  task reconf;
    reconfig = 1'b1;
    step(1);
    reconfig = 1'b0;
    step(2);
    chk(user, 1'b0);
    chk(flt, 1'b1);
    chk(cd_oe_n, 1'b0);
    chk(active, 1'b0);
    step(2);
    chk(active, 1'b1);
  endtask : reconf
  // complete line held low by a far party for hold cycles
  task configure(input int hold);
    pull_cd = 1'b1;
    wait_hi(1'b0);
    chk(cd_oe_n, 1'b1);
    for (i = 0; i < hold; i++) begin
      step(1);
      chk(user, 1'b0);
    end
    pull_cd = 1'b0;
    wait_hi(1'b1);
    chk(user, 1'b1);
    chk(flt, 1'b0);
  endtask : configure
  //----------------------------------------------------------------
  // tests
  //----------------------------------------------------------------
  initial begin
    #100us;
    n_fail++;
    print_verdict;
  end
  initial begin
    {nrst, err, ext_pull, reconfig, host_pull} = 5'h00;
    n_fail   = 0;
    n_checks = 0;
    pull_cd = 1'b1;
    void'($urandom(99));
    step(8);
    chk(st_oe_n, 1'b0);
    chk(cd_oe_n, 1'b0);
    step(8);
    nrst = 1'b1;
    step(POR / 2);
    chk(st_oe_n, 1'b0);
    configure($urandom_range(1, 6));
    chk(st_oe_n, 1'b1);
    for (m = 0; m < 4; m++) begin
      ext_pull = 1'b1;
      pull_cd  = 1'($urandom_range(0, 1));
      step($urandom_range(1, 8));
      ext_pull = 1'b0;
      pull_cd  = 1'b0;
      for (i = 0; i < 20; i++) begin
        step(1);
        chk(user, 1'b1);
      end
    end
    for (m = 0; m < 3; m++) begin
      err       = (m == 0);
      host_pull = (m == 1);
      pull_cd   = 1'b1;
      reconf;
      if (m < 2) begin
        step(20);
        chk(st_oe_n, 1'b0);
        chk(user, 1'b0);
        err       = 1'b0;
        host_pull = 1'b0;
        step(5);
        chk(st_oe_n, 1'b0);
        reconf;
      end
      configure($urandom_range(0, 6));
    end
    print_verdict;
  end
endmodule : testbench
